/* File: logic/swc_top.sv */
// sleep and wake controller: wake qualification, switch timing, rails, fans
// Notes on behaviour
// - network wakes S1/S3/S4; S5 only if enabled
// - recognised wake frame asserts network wake only while asleep and qualified
// - modem ring wakes from S1 or S3 only
// - power switch, rtc alarm wake every state
// - pme wakes S1/S3/S4 when enabled; S5 also needs pme_s5_en
// - pcie wake wakes all states, no enable
// - usb wakes from S1 or S3 only
// - keyboard/mouse wakes from S1 or S3 only
// - wake from S3 returns to S0 through power-up, on power-good ack
// - S3: supply off, led amber or dark
// - fans enabled in S0 and S1
// - fans disabled when off or S3-S5
// - each fan closed loop from tachometer
// - power-off command in S0 drops all non-standby rails
// - after ac loss restore prior state, selectable
// - short press raises os_sleep_btn in S0 or wakes from sleep, long press powers off
`timescale 1ns/1ps
`default_nettype none
module swc_top #(
   parameter longint LONG_PRESS_CYC = swc_pkg::LONG_PRESS_CYC,
   parameter int     NFAN           = 3,
   parameter int     TW             = 16
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rstn,
   input  wire logic                 ac_restored,
   input  wire logic                 restore_last_en,
   input  wire logic                 last_was_on,
   input  wire logic                 net_frame_match,
   input  wire logic                 ring_ind,
   input  wire logic                 pme_n,
   input  wire logic                 pex_wake_n,
   input  wire logic                 pwr_sw,
   input  wire logic                 rtc_alarm,
   input  wire logic                 usb_activity,
   input  wire logic                 kbm_activity,
   input  wire logic                 s5_net_wake_en,
   input  wire logic                 pme_wake_en,
   input  wire logic                 pme_s5_en,
   input  wire logic                 os_sleep_req,
   input  wire logic [2:0]           os_sleep_type,
   input  wire logic                 os_off_cmd,
   input  wire logic                 pwr_good_ack,
   input  wire logic                 led_dual,
   input  wire logic                 fan_full_mode,
   input  wire logic [NFAN-1:0]      fan_tach,
   input  wire logic [TW-1:0]        fan_target,
   output logic                      main_rails_on,
   output logic                      standby_on,
   output logic                      led_green,
   output logic                      led_amber,
   output logic                      net_wake,
   output logic                      os_sleep_btn,
   output logic [2:0]                power_state,
   output logic [swc_pkg::NSRC-1:0]  wake_pending,
   output logic [NFAN-1:0]           fan_pwm,
   output logic [NFAN*TW-1:0]        fan_period
);
   swc_pkg::swc_state_e state_reg, state_next;
   logic [swc_pkg::NSRC-1:0] src_s1_reg, src_s2_reg, src_d_reg, pend_next;
   logic [63:0] press_cnt_reg;
   logic        long_done_reg;
   logic        ac_d_reg;

   // raw source vector, active high
   wire [swc_pkg::NSRC-1:0] src_raw = {kbm_activity, usb_activity, rtc_alarm, pwr_sw,
                                       ~pex_wake_n, ~pme_n, ring_ind, net_frame_match};

   wire in_s1 = state_reg == swc_pkg::SWC_S1;
   wire in_s3 = state_reg == swc_pkg::SWC_S3;
   wire in_s4 = state_reg == swc_pkg::SWC_S4;
   wire in_s5 = state_reg == swc_pkg::SWC_S5;
   wire light = in_s1 | in_s3;
   wire deep  = in_s4 | in_s5;
   wire asleep = light | deep;

   // edges of synchronised sources
   wire [swc_pkg::NSRC-1:0] src_rise = src_s2_reg & ~src_d_reg;
   wire sw_level  = src_s2_reg[swc_pkg::SRC_PWR];
   wire sw_fall   = ~sw_level & src_d_reg[swc_pkg::SRC_PWR];
   wire short_rel = sw_fall & ~long_done_reg;
   wire long_hit  = sw_level & (press_cnt_reg == LONG_PRESS_CYC - 1);

   // per-source qualification by sleeping state
   wire [swc_pkg::NSRC-1:0] qual;
   assign qual[swc_pkg::SRC_NET]  = light | in_s4 | (in_s5 & s5_net_wake_en);
   assign qual[swc_pkg::SRC_RING] = light;
   assign qual[swc_pkg::SRC_PME]  = pme_wake_en & (light | in_s4 | (in_s5 & pme_s5_en));
   assign qual[swc_pkg::SRC_PEX]  = asleep;
   assign qual[swc_pkg::SRC_PWR]  = 1'b0; // switch handled by press timing
   assign qual[swc_pkg::SRC_RTC]  = asleep;
   assign qual[swc_pkg::SRC_USB]  = light;
   assign qual[swc_pkg::SRC_KBM]  = light;

   wire sw_wake = asleep & short_rel;
   wire [swc_pkg::NSRC-1:0] new_wake =
      (src_rise & qual) | ({{(swc_pkg::NSRC-1){1'b0}}, sw_wake} << swc_pkg::SRC_PWR);
   wire ack = (state_reg == swc_pkg::SWC_PUP) & pwr_good_ack;

   // pending wake: set wins over clear, cleared on power-up ack
   always_comb begin
      pend_next = ack ? new_wake : (wake_pending | new_wake);
   end

   // next power state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         swc_pkg::SWC_S0: begin
            if (os_off_cmd || long_hit)
               state_next = swc_pkg::SWC_S5;
            else if (os_sleep_req && os_sleep_type == 3'h1)
               state_next = swc_pkg::SWC_S1;
            else if (os_sleep_req && os_sleep_type == 3'h3)
               state_next = swc_pkg::SWC_S3;
            else if (os_sleep_req && os_sleep_type == 3'h4)
               state_next = swc_pkg::SWC_S4;
            else if (os_sleep_req && os_sleep_type == 3'h5)
               state_next = swc_pkg::SWC_S5;
         end
         swc_pkg::SWC_S1, swc_pkg::SWC_S3, swc_pkg::SWC_S4, swc_pkg::SWC_S5: begin
            if (long_hit && !in_s5)
               state_next = swc_pkg::SWC_S5;
            else if (|new_wake)
               state_next = swc_pkg::SWC_PUP;
         end
         swc_pkg::SWC_PUP: begin
            if (pwr_good_ack)
               state_next = swc_pkg::SWC_S0;
         end
         default: state_next = swc_pkg::SWC_S5;
      endcase
      if (ac_restored && !ac_d_reg)
         state_next = (restore_last_en && last_was_on) ? swc_pkg::SWC_PUP
                                                       : swc_pkg::SWC_S5;
   end

   // state, synchronisers and press timer
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_reg     <= swc_pkg::SWC_S5;
         src_s1_reg    <= '0;
         src_s2_reg    <= '0;
         src_d_reg     <= '0;
         wake_pending  <= '0;
         press_cnt_reg <= 64'h0;
         long_done_reg <= 1'b0;
         ac_d_reg      <= 1'b0;
      end else begin
         src_s1_reg   <= src_raw;
         src_s2_reg   <= src_s1_reg;
         src_d_reg    <= src_s2_reg;
         ac_d_reg     <= ac_restored;
         state_reg    <= state_next;
         wake_pending <= pend_next;
         if (!sw_level) begin
            press_cnt_reg <= 64'h0;
            if (sw_fall)
               long_done_reg <= 1'b0;
         end else if (long_hit) begin
            long_done_reg <= 1'b1;
            press_cnt_reg <= press_cnt_reg + 64'h1;
         end else if (!long_done_reg) begin
            press_cnt_reg <= press_cnt_reg + 64'h1;
         end
      end
   end

   // registered outputs
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         main_rails_on <= 1'b0;
         standby_on    <= 1'b1;
         led_green     <= 1'b0;
         led_amber     <= 1'b0;
         net_wake      <= 1'b0;
         os_sleep_btn  <= 1'b0;
         power_state   <= swc_pkg::SWC_S5;
      end else begin
         main_rails_on <= (state_next == swc_pkg::SWC_S0) | (state_next == swc_pkg::SWC_S1)
                        | (state_next == swc_pkg::SWC_PUP);
         standby_on    <= 1'b1;
         led_green     <= (state_next == swc_pkg::SWC_S0);
         led_amber     <= (state_next == swc_pkg::SWC_S3) & led_dual;
         net_wake      <= src_rise[swc_pkg::SRC_NET] & qual[swc_pkg::SRC_NET];
         os_sleep_btn  <= (state_reg == swc_pkg::SWC_S0) & short_rel;
         power_state   <= state_next;
      end
   end

   wire fan_allow = (state_reg == swc_pkg::SWC_S0) | in_s1;

   // fan channels
   genvar g;
   generate
      for (g = 0; g < NFAN; g++) begin : g_fan
         swc_fan_loop #(.W(TW)) u_fan (
            .ref_clk       (ref_clk),
            .rstn          (rstn),
            .fan_allow     (fan_allow),
            .full_mode     (fan_full_mode),
            .tach          (fan_tach[g]),
            .target_period (fan_target),
            .fan_pwm       (fan_pwm[g]),
            .tach_period   (fan_period[g*TW +: TW])
         );
      end
   endgenerate
endmodule
`default_nettype wire

/* File: logic/swc_pkg.sv */
// shared constants and state codes for the sleep and wake controller
package swc_pkg;
   // system power states
   typedef enum logic [2:0] {
      SWC_S0  = 3'h0,
      SWC_S1  = 3'h1,
      SWC_S3  = 3'h3,
      SWC_S4  = 3'h4,
      SWC_S5  = 3'h5,
      SWC_PUP = 3'h6
   } swc_state_e;
   // wake source bit positions
   localparam int SRC_NET  = 0;
   localparam int SRC_RING = 1;
   localparam int SRC_PME  = 2;
   localparam int SRC_PEX  = 3;
   localparam int SRC_PWR  = 4;
   localparam int SRC_RTC  = 5;
   localparam int SRC_USB  = 6;
   localparam int SRC_KBM  = 7;
   localparam int NSRC     = 8;
   // power switch hold threshold
   localparam real   CLK_MHZ       = 200.0;
   localparam real   LONG_PRESS_S  = 4.0;
   localparam longint LONG_PRESS_CYC = longint'(LONG_PRESS_S * CLK_MHZ * 1.0e6);
   // fan control
   localparam int FAN_PWM_W = 8;
   localparam logic [7:0] FAN_FULL = 8'hff;
   localparam logic [7:0] FAN_STEP = 8'h04;
   // reset values
   localparam logic [2:0] LAST_ON_RST = 3'h0;
endpackage

/* File: logic/swc_fan_loop.sv */
// one closed-loop fan channel: tach period against target, pwm out
`timescale 1ns/1ps
`default_nettype none
module swc_fan_loop #(
   parameter int W = 16
) (
   input  wire logic         ref_clk,
   input  wire logic         rstn,
   input  wire logic         fan_allow,
   input  wire logic         full_mode,
   input  wire logic         tach,
   input  wire logic [W-1:0] target_period,
   output logic              fan_pwm,
   output logic [W-1:0]      tach_period
);
   logic [W-1:0] cnt_reg;
   logic [7:0]   duty_reg;
   logic [7:0]   pwm_cnt_reg;
   logic         tach_d_reg;
   wire          tach_rise = tach & ~tach_d_reg;
   wire          too_slow  = cnt_reg > target_period;
   wire          sat       = &cnt_reg;

   // period measurement and duty adjustment
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cnt_reg     <= '0;
         duty_reg    <= swc_pkg::FAN_FULL; // start at full, ease down on tach
         pwm_cnt_reg <= 8'h00;
         tach_d_reg  <= 1'b0;
         tach_period <= '0;
         fan_pwm     <= 1'b0;
      end else begin
         tach_d_reg  <= tach;
         pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
         if (tach_rise) begin
            tach_period <= cnt_reg;
            cnt_reg     <= '0;
            if (too_slow && duty_reg <= swc_pkg::FAN_FULL - swc_pkg::FAN_STEP)
               duty_reg <= duty_reg + swc_pkg::FAN_STEP;
            else if (!too_slow && duty_reg >= swc_pkg::FAN_STEP)
               duty_reg <= duty_reg - swc_pkg::FAN_STEP;
         end else if (!sat) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else begin
            duty_reg <= swc_pkg::FAN_FULL; // stalled fan, drive full
         end
         if (!fan_allow)
            fan_pwm <= 1'b0;
         else if (full_mode)
            fan_pwm <= 1'b1;
         else
            fan_pwm <= (pwm_cnt_reg < duty_reg) || (duty_reg == swc_pkg::FAN_FULL);
      end
   end
endmodule
`default_nettype wire

/* File: tb/swc_psu.sv */
// power supply and fan model: power-good ack, tachometer pulses
`timescale 1ns/1ps
`default_nettype none
module swc_psu #(
   parameter int ACK_DLY = 16,
   parameter int NFAN    = 3
) (
   input  wire logic            ref_clk,
   input  wire logic            main_rails_on,
   input  wire logic [2:0]      power_state,
   input  wire logic [NFAN-1:0] fan_pwm,
   output logic                 pwr_good_ack,
   output logic [NFAN-1:0]      fan_tach
);
   int         cnt = 0;
   logic [2:0] div = 3'h0;
   initial begin
      pwr_good_ack = 1'b0;
      fan_tach = '0;
   end
   // good only once rails have stood a while; tach spins while driven
   always @(posedge ref_clk) begin
      cnt <= (main_rails_on && power_state == 3'h6) ? cnt + 1 : 0;
      pwr_good_ack <= (cnt == ACK_DLY - 1);
      div <= div + 3'h1;
      if (div == 3'h7) fan_tach <= fan_tach ^ fan_pwm;
   end
endmodule
`default_nettype wire

/* File: tb/swc_sva.sv */
// checker: state outputs, wake qualification, pending lifetime
`timescale 1ns/1ps
`default_nettype none
module swc_sva #(
   parameter int NFAN = 3
) (
   input wire logic                     ref_clk,
   input wire logic                     rstn,
   input wire logic                     led_dual,
   input wire logic                     pme_wake_en,
   input wire logic                     s5_net_wake_en,
   input wire logic                     pwr_good_ack,
   input wire logic                     main_rails_on,
   input wire logic                     led_green,
   input wire logic                     led_amber,
   input wire logic [2:0]               power_state,
   input wire logic [swc_pkg::NSRC-1:0] wake_pending,
   input wire logic [NFAN-1:0]          fan_pwm
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   AST_FAN_OFF: assert property (
      (power_state inside {3'h3, 3'h4, 3'h5, 3'h6})[*3] |-> fan_pwm == '0) else $error("fan on");
   AST_S3_LED: assert property (
      power_state == 3'h3 && $past(power_state) == 3'h3
      |-> !main_rails_on && !led_green && led_amber == led_dual) else $error("s3 outputs");
   AST_RING: assert property (
      $rose(wake_pending[1]) |-> $past(power_state) inside {3'h1, 3'h3}) else $error("ring");
   AST_USB: assert property (
      $rose(wake_pending[6]) |-> $past(power_state) inside {3'h1, 3'h3}) else $error("usb");
   AST_KBM: assert property (
      $rose(wake_pending[7]) |-> $past(power_state) inside {3'h1, 3'h3}) else $error("kbm");
   AST_NET_S5: assert property (
      $rose(wake_pending[0]) && $past(power_state) == 3'h5 |-> s5_net_wake_en) else $error("net");
   AST_PME: assert property (
      $rose(wake_pending[2]) |-> pme_wake_en) else $error("pme");
   AST_HOLD: assert property (
      power_state == 3'h6 && !pwr_good_ack |=> power_state == 3'h6) else $error("left power-up");
   AST_ACK: assert property (
      power_state == 3'h6 && pwr_good_ack |=> power_state == 3'h0 ##1 wake_pending == '0)
      else $error("ack");
   AST_S5_RAILS: assert property (
      power_state == 3'h5 && $past(power_state) == 3'h5 |-> !main_rails_on) else $error("rails");
   cover property (power_state == 3'h3 ##1 power_state == 3'h6);
   cover property (power_state == 3'h0 ##1 power_state == 3'h5);
   cover property ($rose(wake_pending[0]) && $past(power_state) == 3'h5);
   cover property (power_state == 3'h6 && pwr_good_ack);
endmodule
bind swc_top swc_sva #(.NFAN(NFAN)) u_sva (.ref_clk, .rstn, .led_dual, .pme_wake_en,
   .s5_net_wake_en, .pwr_good_ack, .main_rails_on, .led_green, .led_amber, .power_state,
   .wake_pending, .fan_pwm);
`default_nettype wire

/* File: tb/test_sleep_wake_controller.sv */
// testbench: wake table per state, sleep entry, switch, off, ac restore
`timescale 1ns/1ps
`default_nettype none
module test_sleep_wake_controller;
   logic ref_clk = 0, rstn = 0, ac_restored = 0, restore_last_en = 0, last_was_on = 0;
   logic os_sleep_req = 0, os_off_cmd = 0, s5_net_wake_en = 0, pme_wake_en = 1;
   logic pme_s5_en = 0, led_dual = 0, q, pwr_good_ack, net_wake, os_sleep_btn;
   logic main_rails_on, standby_on, led_green, led_amber, fan_full_mode = 0;
   logic [2:0] os_sleep_type = 3'h3, power_state, fan_tach, fan_pwm;
   logic [7:0] src = 8'h00, wake_pending;
   logic [2:0] seen = 3'h0;
   logic [47:0] fan_period;
   int         miscompares = 0, tests_run = 0, sts[4] = '{1, 3, 4, 5};
   wire net_frame_match = src[0], ring_ind = src[1], pme_n = ~src[2], pex_wake_n = ~src[3];
   wire pwr_sw = src[4], rtc_alarm = src[5], usb_activity = src[6], kbm_activity = src[7];
   always #2.5 ref_clk = ~ref_clk;
   // sticky record of one-cycle pulses
   always @(posedge ref_clk)
      seen <= seen | {fan_pwm[0] === 1'b0, os_sleep_btn === 1'b1, net_wake === 1'b1};
   swc_top #(.LONG_PRESS_CYC(20)) dut (.ref_clk, .rstn, .ac_restored, .restore_last_en,
      .last_was_on, .net_frame_match, .ring_ind, .pme_n, .pex_wake_n, .pwr_sw, .rtc_alarm,
      .usb_activity, .kbm_activity, .s5_net_wake_en, .pme_wake_en, .pme_s5_en, .os_sleep_req,
      .os_sleep_type, .os_off_cmd, .pwr_good_ack, .led_dual, .fan_full_mode, .fan_tach,
      .fan_target(16'h0040), .main_rails_on, .standby_on, .led_green, .led_amber, .net_wake,
      .os_sleep_btn, .power_state, .wake_pending, .fan_pwm, .fan_period);
   swc_psu u_psu (.ref_clk, .main_rails_on, .power_state, .fan_pwm, .pwr_good_ack, .fan_tach);
   task automatic chk(logic [15:0] v, logic [15:0] e, string nm);
      tests_run++;
      if (v !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, v);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic pulse(int b);
      src[b] = 1'b1;
      cyc(1);
      src[b] = 1'b0;
   endtask
   task automatic to_s0;
      if (power_state !== 3'h0 && power_state !== 3'h6) pulse(5);
      for (int k = 0; k < 60 && power_state !== 3'h0; k++) cyc(1);
      cyc(1);
      chk({power_state, wake_pending}, 16'h0000, "s0 entry");
   endtask
   task automatic goto(int t);
      to_s0();
      os_sleep_type = t[2:0];
      os_sleep_req = 1'b1;
      cyc(1);
      os_sleep_req = 1'b0;
      cyc(6);
      chk(power_state, t[15:0], "sleep state");
      if (t == 3) chk({main_rails_on, led_amber}, {1'b0, led_dual}, "s3 rails led");
   endtask
   function automatic logic qual(int s, int t);
      case (s)
         0: return t != 5 || s5_net_wake_en;
         2: return pme_wake_en && (t != 5 || pme_s5_en);
         1, 6, 7: return t == 1 || t == 3;
         default: return 1'b1;
      endcase
   endfunction
   task automatic results;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #200us;
      miscompares++;
      results();
   end
   initial begin
      cyc(12);
      rstn = 1'b1;
      cyc(1);
      chk({power_state, main_rails_on, standby_on}, 16'h0015, "reset");
      for (int p = 0; p < 3; p++)
         for (int i = 0; i < 4; i++)
            for (int s = 0; s < 8; s++) begin
               {s5_net_wake_en, pme_s5_en, pme_wake_en, led_dual} = {p > 0, p > 0, p < 2, p[0]};
               goto(sts[i]);
               q = qual(s, sts[i]);
               seen = 3'h0;
               pulse(s); // each source reaches the block unmasked
               cyc(8);
               chk({power_state, wake_pending[s]}, {q ? 3'h6 : sts[i][2:0], q}, "wake");
               if (s == 0) chk(seen[0], q, "net wake pulse");
            end
      to_s0();
      seen = 3'h0;
      src[4] = 1'b1;
      cyc(3);
      src[4] = 1'b0;
      cyc(8);
      chk({power_state, seen[1]}, 16'h0001, "short press");
      src[4] = 1'b1;
      cyc(30);
      src[4] = 1'b0;
      cyc(4);
      chk(power_state, 16'h0005, "long press");
      // fans: full mode holds them on, closed loop eases a fast fan
      to_s0();
      fan_full_mode = 1'b1;
      cyc(40);
      seen = 3'h0;
      cyc(256);
      chk(seen[2], 1'b0, "fans full in s0");
      chk(fan_period[15:0] inside {[16'h0001:16'h003f]}, 1'b1, "tach period");
      fan_full_mode = 1'b0;
      cyc(600);
      chk(seen[2], 1'b1, "closed loop eases fans");
      fan_full_mode = 1'b1;
      goto(1);
      chk(fan_pwm, 3'h7, "fans on in s1");
      goto(3);
      chk(fan_pwm, 3'h0, "fans off in s3");
      fan_full_mode = 1'b0;
      to_s0();
      os_off_cmd = 1'b1;
      cyc(1);
      os_off_cmd = 1'b0;
      cyc(6);
      chk({power_state, main_rails_on, standby_on}, 16'h0015, "off cmd");
      {restore_last_en, last_was_on, ac_restored} = 3'h7;
      cyc(6);
      chk(power_state, 16'h0006, "ac restore on");
      // ac lost and back while running, last state recorded as off
      to_s0();
      {last_was_on, ac_restored} = 2'h0;
      cyc(2);
      ac_restored = 1'b1;
      cyc(6);
      chk(power_state, 16'h0005, "ac restore off");
      // restore not selected: stays off even though last state was on
      to_s0();
      {restore_last_en, last_was_on, ac_restored} = 3'h2;
      cyc(2);
      ac_restored = 1'b1;
      cyc(6);
      chk(power_state, 16'h0005, "ac restore disabled");
      results();
   end
endmodule
`default_nettype wire
